// *** hdl/ssr_supervisor.sv ***
// Purpose: Supply detector, undervoltage reset, watchdog and range checker with
//          an Avalon-MM register slave.
// Assumes: Comparator, oscillator and option inputs are asynchronous pins;
//          fetch and power-down inputs are synchronous to clk.
// Notes: Flags survive reset_request; only rst_n (power-on) or a software write clears them.
`timescale 1ns/1ps

// Summary of operation
// - Enable bit turns supply detection on
// - Status flag follows filtered detect condition
// - Interrupt flag sticky until software clears
// - Four-bit code selects detection threshold
// - Condition must persist through debounce interval
// - Detector interrupt wakes from power-down
// - Undervoltage reset after filtered supply drop
// - Undervoltage reset enabled only by option
// - Reset on program counter out of range
// - Reset on illegal opcode fetch
// - Range reset sets watchdog overflow flag
// - Watchdog counts down on oscillator edges
// - Watchdog overflow resets the device
// - Watchdog enable fixed by option
// - Overflow sets watchdog overflow flag
// - Reset status access restarts watchdog
// - Three-bit field selects watchdog period
// - Period codes map 4096 ms to 1 ms
// - Overflow flag bit 7, software clears
// - Undervoltage flag bit 4, software clears
module ssr_supervisor #(
	parameter int DEBOUNCE_CYCLES = ssr_pkg::DEBOUNCE_CYCLES,
	parameter int RESET_HOLD = ssr_pkg::RESET_HOLD_CYCLES,
	parameter int EDGES_PER_MS = ssr_pkg::RC_EDGES_PER_MS,
	parameter int PROG_MEM_SIZE = ssr_pkg::PROG_MEM_SIZE
) (
	input wire logic clk, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic [ssr_pkg::ADDR_W-1:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Byte enables
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall request
	input wire logic supply_below_detect, // Comparator: supply below detect level
	input wire logic supply_at_or_below_uv, // Comparator: supply at or below uv level
	input wire logic rc_osc_clk, // Watchdog oscillator pin
	input wire logic opt_uv_reset_enable, // Option: undervoltage reset on
	input wire logic opt_uv_threshold_high, // Option: 1 selects 4.3 V, 0 selects 2.1 V
	input wire logic opt_watchdog_enable, // Option: watchdog on
	input wire logic [ssr_pkg::PC_W-1:0] pc_value, // Program counter of fetch
	input wire logic fetch_valid, // Fetch strobe
	input wire logic [7:0] fetch_opcode, // Fetched opcode
	input wire logic power_down, // Processor in power-down
	output logic [3:0] detector_threshold_select, // Detect level code to comparator
	output logic undervoltage_threshold, // Uv level select to comparator
	output logic detector_interrupt, // Detector interrupt flag level
	output logic wake_request, // Wake from power-down
	output logic reset_request // System reset, active high
);
	localparam int NSYNC = 6;
	localparam int HW = $clog2(RESET_HOLD + 1);
	localparam logic [ssr_pkg::PC_W:0] PC_LIMIT = (ssr_pkg::PC_W + 1)'(PROG_MEM_SIZE);

	// Pin synchronisers
	logic [NSYNC-1:0] sync_meta;
	logic [NSYNC-1:0] sync_q;
	logic below_detect_s;
	logic below_uv_s;
	logic rc_s;
	logic uv_enable_s;
	logic uv_high_s;
	logic wdt_enable_s;
	logic rc_prev;
	logic rc_tick;

	// Registers
	logic detector_enable;
	logic detector_polarity_select;
	logic detector_interrupt_flag;
	logic watchdog_overflow_flag;
	logic power_on_flag;
	logic undervoltage_reset_flag;
	logic [2:0] watchdog_period_select;
	logic detector_status_flag;

	// Bus
	logic bus_req;
	logic bus_ack;
	logic [7:0] word_index;
	logic word_aligned;
	logic hit_detect;
	logic hit_status;
	logic wr_detect;
	logic wr_status;
	logic status_access;
	logic [7:0] next_readdata;

	// Functions
	logic detect_cond;
	logic detect_stable;
	logic detect_prev;
	logic detect_event;
	logic uv_cond;
	logic uv_active;
	logic uv_prev;
	logic uv_event;
	logic wdt_overflow;
	logic program_range_reset;
	logic [HW-1:0] hold_count;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync_meta <= '0;
			sync_q <= '0;
		end else begin
			sync_meta <= {opt_watchdog_enable, opt_uv_threshold_high, opt_uv_reset_enable,
				rc_osc_clk, supply_at_or_below_uv, supply_below_detect};
			sync_q <= sync_meta;
		end
	end

	assign below_detect_s = sync_q[0];
	assign below_uv_s = sync_q[1];
	assign rc_s = sync_q[2];
	assign uv_enable_s = sync_q[3];
	assign uv_high_s = sync_q[4];
	assign wdt_enable_s = sync_q[5];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rc_prev <= 1'b0;
		end else begin
			rc_prev <= rc_s;
		end
	end

	assign rc_tick = rc_s && !rc_prev;

	// Bus decode: one wait cycle, then the answer
	assign bus_req = avs_read || avs_write;
	assign avs_waitrequest = bus_req && !bus_ack;
	assign word_index = avs_address[9:2];
	assign word_aligned = (avs_address[1:0] == 2'h0);
	assign hit_detect = word_aligned && (word_index == ssr_pkg::IDX_DETECT_CONTROL);
	assign hit_status = word_aligned && (word_index == ssr_pkg::IDX_RESET_STATUS);
	assign wr_detect = avs_write && bus_ack && hit_detect && avs_byteenable[0];
	assign wr_status = avs_write && bus_ack && hit_status && avs_byteenable[0];
	assign status_access = bus_req && bus_ack && hit_status;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= bus_req && !bus_ack;
		end
	end

	always_comb begin
		next_readdata = 8'h00;
		if (hit_detect) begin
			next_readdata[ssr_pkg::DC_ENABLE_BIT] = detector_enable;
			next_readdata[ssr_pkg::DC_STATUS_BIT] = detector_status_flag;
			next_readdata[ssr_pkg::DC_POLARITY_BIT] = detector_polarity_select;
			next_readdata[ssr_pkg::DC_IRQ_BIT] = detector_interrupt_flag;
			next_readdata[ssr_pkg::DC_THRESH_LSB +: ssr_pkg::DC_THRESH_W] =
				detector_threshold_select;
		end else if (hit_status) begin
			next_readdata[ssr_pkg::RS_WATCHDOG_OVERFLOW_FLAG_BIT] = watchdog_overflow_flag;
			next_readdata[ssr_pkg::RS_POWER_ON_BIT] = power_on_flag;
			next_readdata[ssr_pkg::RS_UV_BIT] = undervoltage_reset_flag;
			next_readdata[ssr_pkg::RS_PERIOD_LSB +: ssr_pkg::RS_PERIOD_W] =
				watchdog_period_select;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && !bus_ack) begin
			avs_readdata <= {24'h00_0000, next_readdata};
		end
	end

	// Detector control fields written by software
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			detector_enable <= ssr_pkg::DC_RESET[ssr_pkg::DC_ENABLE_BIT];
			detector_polarity_select <= ssr_pkg::DC_RESET[ssr_pkg::DC_POLARITY_BIT];
			detector_threshold_select <=
				ssr_pkg::DC_RESET[ssr_pkg::DC_THRESH_LSB +: ssr_pkg::DC_THRESH_W];
		end else if (wr_detect) begin
			detector_enable <= avs_writedata[ssr_pkg::DC_ENABLE_BIT];
			detector_polarity_select <= avs_writedata[ssr_pkg::DC_POLARITY_BIT];
			detector_threshold_select <=
				avs_writedata[ssr_pkg::DC_THRESH_LSB +: ssr_pkg::DC_THRESH_W];
		end
	end

	assign detect_cond = detector_enable &&
		(detector_polarity_select ? !below_detect_s : below_detect_s);

	ssr_debounce #(
		.CYCLES(DEBOUNCE_CYCLES)
	) u_detect_filter (
		.clk(clk),
		.rst_n(rst_n),
		.cond(detect_cond),
		.stable(detect_stable)
	);

	assign detector_status_flag = detect_stable;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			detect_prev <= 1'b0;
		end else begin
			detect_prev <= detect_stable;
		end
	end

	assign detect_event = detect_stable && !detect_prev;

	// sticky flag, set wins over clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			detector_interrupt_flag <= ssr_pkg::DC_RESET[ssr_pkg::DC_IRQ_BIT];
		end else if (detect_event) begin
			detector_interrupt_flag <= 1'b1;
		end else if (wr_detect && !avs_writedata[ssr_pkg::DC_IRQ_BIT]) begin
			detector_interrupt_flag <= 1'b0;
		end
	end

	assign detector_interrupt = detector_interrupt_flag;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wake_request <= 1'b0;
		end else begin
			wake_request <= power_down && detector_interrupt_flag;
		end
	end

	assign uv_cond = uv_enable_s && below_uv_s;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			undervoltage_threshold <= 1'b0;
		end else begin
			undervoltage_threshold <= uv_high_s;
		end
	end

	ssr_debounce #(
		.CYCLES(DEBOUNCE_CYCLES)
	) u_uv_filter (
		.clk(clk),
		.rst_n(rst_n),
		.cond(uv_cond),
		.stable(uv_active)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			uv_prev <= 1'b0;
		end else begin
			uv_prev <= uv_active;
		end
	end

	assign uv_event = uv_active && !uv_prev;

	assign program_range_reset = fetch_valid &&
		(({1'b0, pc_value} >= PC_LIMIT) || (fetch_opcode == ssr_pkg::ILLEGAL_OPCODE));

	ssr_watchdog #(
		.EDGES_PER_MS(EDGES_PER_MS)
	) u_watchdog (
		.clk(clk),
		.rst_n(rst_n),
		.enable(wdt_enable_s),
		.tick(rc_tick),
		.restart(status_access),
		.period_sel(watchdog_period_select),
		.overflow(wdt_overflow)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			watchdog_period_select <= ssr_pkg::RS_PERIOD_RESET;
		end else if (wr_status) begin
			watchdog_period_select <=
				avs_writedata[ssr_pkg::RS_PERIOD_LSB +: ssr_pkg::RS_PERIOD_W];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			watchdog_overflow_flag <= ssr_pkg::RS_WATCHDOG_OVERFLOW_FLAG_RESET;
		end else if (wdt_overflow || program_range_reset) begin
			watchdog_overflow_flag <= 1'b1;
		end else if (wr_status) begin
			watchdog_overflow_flag <= avs_writedata[ssr_pkg::RS_WATCHDOG_OVERFLOW_FLAG_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			undervoltage_reset_flag <= ssr_pkg::RS_UV_RESET;
		end else if (uv_event) begin
			undervoltage_reset_flag <= 1'b1;
		end else if (wr_status) begin
			undervoltage_reset_flag <= avs_writedata[ssr_pkg::RS_UV_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			power_on_flag <= ssr_pkg::RS_POWER_ON_RESET;
		end else if (wr_status) begin
			power_on_flag <= avs_writedata[ssr_pkg::RS_POWER_ON_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hold_count <= '0;
		end else if (wdt_overflow || program_range_reset) begin
			hold_count <= HW'(RESET_HOLD);
		end else if (hold_count != '0) begin
			hold_count <= hold_count - HW'(1);
		end
	end

	// uv reset while filtered drop holds
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reset_request <= 1'b0;
		end else begin
			reset_request <= uv_active || (hold_count != '0) || wdt_overflow ||
				program_range_reset;
		end
	end
endmodule // ssr_supervisor

// *** hdl/ssr_pkg.sv ***
// Purpose: Shared constants for the supply reset supervisor.
// Assumes: 250 MHz clock, registers one byte wide in the low lane of a 32-bit word.
// Notes: Register indices are word indices; byte address is four times the index.
package ssr_pkg;
	// Clock and timing
	localparam int CLK_PERIOD_PS = 4000;
	localparam int DEBOUNCE_MIN_US = 30;
	localparam int DEBOUNCE_CYCLES = (DEBOUNCE_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RESET_HOLD_CYCLES = 16;
	localparam int RC_EDGES_PER_MS = 2;

	// Register indices and bus
	localparam int ADDR_W = 10;
	localparam logic [7:0] IDX_RESET_STATUS = 8'hb1;
	localparam logic [7:0] IDX_DETECT_CONTROL = 8'hb3;

	// Detector control fields
	localparam int DC_ENABLE_BIT = 7;
	localparam int DC_STATUS_BIT = 6;
	localparam int DC_POLARITY_BIT = 5;
	localparam int DC_IRQ_BIT = 4;
	localparam int DC_THRESH_LSB = 0;
	localparam int DC_THRESH_W = 4;
	localparam logic [7:0] DC_RESET = 8'h00;

	// Reset status fields
	localparam int RS_WATCHDOG_OVERFLOW_FLAG_BIT = 7;
	localparam int RS_POWER_ON_BIT = 5;
	localparam int RS_UV_BIT = 4;
	localparam int RS_PERIOD_LSB = 0;
	localparam int RS_PERIOD_W = 3;
	localparam logic RS_WATCHDOG_OVERFLOW_FLAG_RESET = 1'b0;
	localparam logic RS_POWER_ON_RESET = 1'b1;
	localparam logic RS_UV_RESET = 1'b0;
	localparam logic [2:0] RS_PERIOD_RESET = 3'h0;

	// Watchdog minimum periods in ms, indexed by period code
	localparam int WDT_CNT_W = 24;
	localparam logic [12:0] WDT_PERIOD_MS [8] = '{
		13'h1000, 13'h0400, 13'h0100, 13'h0080, 13'h0040, 13'h0010, 13'h0004, 13'h0001
	};

	// Range checker
	localparam logic [7:0] ILLEGAL_OPCODE = 8'ha5;
	localparam int PC_W = 16;
	localparam int PROG_MEM_SIZE = 16384;

	// Threshold detector: 2.40 V at code 0, 0.15 V per step (in mV)
	localparam int DETECT_BASE_MV = 2400;
	localparam int DETECT_STEP_MV = 150;
endpackage

// *** hdl/ssr_debounce.sv ***
// Purpose: Persistence filter for a supply condition.
// Assumes: cond is already synchronous to clk.
// Notes: Output drops in the same cycle the condition drops.
`timescale 1ns/1ps
module ssr_debounce #(
	parameter int CYCLES = 7500
) (
	input wire logic clk, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic cond, // Raw condition
	output logic stable // Condition held for CYCLES cycles
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
	logic [CW-1:0] count;

	always_ff @(posedge clk) begin
		if (!rst_n || !cond) begin
			count <= '0;
		end else if (count != LAST) begin
			count <= count + CW'(1);
		end
	end

	assign stable = cond && (count == LAST);
endmodule // ssr_debounce

// *** hdl/ssr_watchdog.sv ***
// Purpose: Watchdog down counter stepped by oscillator edges.
// Assumes: tick is a one-cycle pulse per oscillator edge.
// Notes: Reloads on restart and after each overflow.
`timescale 1ns/1ps
module ssr_watchdog #(
	parameter int EDGES_PER_MS = ssr_pkg::RC_EDGES_PER_MS
) (
	input wire logic clk, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic enable, // Watchdog enabled by option
	input wire logic tick, // Oscillator edge pulse
	input wire logic restart, // Restart the count
	input wire logic [2:0] period_sel, // Overflow period code
	output logic overflow // One-cycle overflow pulse
);
	localparam int W = ssr_pkg::WDT_CNT_W;
	logic [W-1:0] count;
	logic [W-1:0] next_load;

	always_comb begin
		next_load = W'(32'(ssr_pkg::WDT_PERIOD_MS[period_sel]) * EDGES_PER_MS);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count <= W'(32'(ssr_pkg::WDT_PERIOD_MS[0]) * EDGES_PER_MS);
			overflow <= 1'b0;
		end else if (!enable || restart) begin
			count <= next_load;
			overflow <= 1'b0;
		end else if (tick) begin
			if (count <= W'(1)) begin
				count <= next_load;
				overflow <= 1'b1;
			end else begin
				count <= count - W'(1);
				overflow <= 1'b0;
			end
		end else begin
			overflow <= 1'b0;
		end
	end
endmodule // ssr_watchdog

// *** testbench/ssr_supply_model.sv ***
// Purpose: Supply comparators and free-running watchdog oscillator.
// Assumes: The bench sets the supply level in mV.
// Notes: Oscillator period 42 ns, unrelated in phase to clk.
`timescale 1ns/1ps
module ssr_supply_model (
	input wire logic [12:0] supply_mv, // Supply level in mV
	input wire logic [3:0] detect_code, // Detect level code
	input wire logic uv_high, // Undervoltage level select
	output logic below, // Supply below detect level
	output logic uv, // Supply at or below uv level
	output logic rc_osc // Watchdog oscillator
);
	logic osc = 1'b0;
	assign below = int'(supply_mv) <
		ssr_pkg::DETECT_BASE_MV + ssr_pkg::DETECT_STEP_MV * int'(detect_code);
	assign uv = int'(supply_mv) <= (uv_high ? 4300 : 2100);
	always #21 osc = ~osc;
	assign rc_osc = osc;
endmodule // ssr_supply_model

// *** testbench/ssr_supervisor_monitor.sv ***
// Purpose: Port checks for the supervisor.
// Assumes: Bound to every ssr_supervisor instance.
// Notes: Sees only top-level ports.
`timescale 1ns/1ps
module ssr_supervisor_monitor #(
	parameter int PROG_MEM_SIZE = ssr_pkg::PROG_MEM_SIZE
) (
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset
	input wire logic [ssr_pkg::ADDR_W-1:0] avs_address, // Address
	input wire logic avs_read, // Read
	input wire logic avs_write, // Write
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Byte enables
	input wire logic [31:0] avs_readdata, // Read data
	input wire logic avs_waitrequest, // Stall
	input wire logic supply_below_detect, // Comparator
	input wire logic supply_at_or_below_uv, // Comparator
	input wire logic rc_osc_clk, // Oscillator
	input wire logic opt_uv_reset_enable, // Option
	input wire logic opt_uv_threshold_high, // Option
	input wire logic opt_watchdog_enable, // Option
	input wire logic [ssr_pkg::PC_W-1:0] pc_value, // Fetch address
	input wire logic fetch_valid, // Fetch strobe
	input wire logic [7:0] fetch_opcode, // Opcode
	input wire logic power_down, // Power-down
	input wire logic [3:0] detector_threshold_select, // Level code
	input wire logic undervoltage_threshold, // Uv level
	input wire logic detector_interrupt, // Interrupt flag
	input wire logic wake_request, // Wake
	input wire logic reset_request // System reset
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic bus_req;
	logic ctl_wr;
	logic hit;
	logic wake_cause;
	logic [3:0] wd_lo;
	assign bus_req = avs_read | avs_write;
	assign ctl_wr = avs_write & !avs_waitrequest & avs_byteenable[0] &
		(avs_address == {ssr_pkg::IDX_DETECT_CONTROL, 2'h0});
	assign hit = fetch_valid & ((int'(pc_value) >= PROG_MEM_SIZE) |
		(fetch_opcode == ssr_pkg::ILLEGAL_OPCODE));
	assign wake_cause = power_down & detector_interrupt;
	assign wd_lo = avs_writedata[3:0];
	AST_WAIT_FIRST: assert property (bus_req && !$past(bus_req) |-> avs_waitrequest)
		else $error("no wait state on new request");
	AST_WAIT_ONE: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait state longer than one cycle");
	AST_NO_WAIT_IDLE: assert property (!bus_req |-> !avs_waitrequest)
		else $error("wait without request");
	AST_UPPER_ZERO: assert property (avs_readdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	AST_IRQ_STICKY: assert property (detector_interrupt && !ctl_wr |=> detector_interrupt)
		else $error("interrupt flag cleared by hardware");
	AST_THRESH: assert property (ctl_wr |=> detector_threshold_select == $past(wd_lo))
		else $error("threshold code not updated");
	AST_WAKE: assert property (1'b1 |=> wake_request == $past(wake_cause))
		else $error("wake request mismatch");
	AST_RANGE: assert property (hit |=> reset_request [*8])
		else $error("range fault without reset");
	AST_UV_SEL: assert property ($stable(opt_uv_threshold_high) [*5] |->
		undervoltage_threshold == opt_uv_threshold_high)
		else $error("uv level select mismatch");
	cover property (hit);
	cover property ($rose(detector_interrupt));
	cover property ($rose(wake_request));
	cover property (ctl_wr);
endmodule // ssr_supervisor_monitor

bind ssr_supervisor ssr_supervisor_monitor #(.PROG_MEM_SIZE(PROG_MEM_SIZE))
	ssr_supervisor_monitor_inst (.*);

// *** testbench/tb_ssr_supervisor.sv ***
// Purpose: Register-level tests of the supervisor.
// Assumes: Short debounce and one oscillator edge per ms.
// Notes: Bus tasks hold each request until waitrequest is low.
`timescale 1ns/1ps
module tb_ssr_supervisor;
	localparam int DEB = 8;
	localparam int HOLD = 16;
	localparam int LAT = DEB + 6;
	localparam logic [9:0] A_CTL = {ssr_pkg::IDX_DETECT_CONTROL, 2'h0};
	localparam logic [9:0] A_STAT = {ssr_pkg::IDX_RESET_STATUS, 2'h0};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [9:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [3:0] avs_byteenable = 4'h1;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic below, uv, rc;
	logic opt_uv_en = 1'b0;
	logic opt_uv_hi = 1'b0;
	logic opt_wd_en = 1'b0;
	logic [15:0] pc = '0;
	logic fetch = 1'b0;
	logic [7:0] opcode = '0;
	logic power_down = 1'b0;
	logic [3:0] thr_sel;
	logic uv_thr, irq, wake, rst_req;
	logic [12:0] supply_mv = 13'd5000;
	logic [31:0] rd;
	int failures = 0;
	int samples_checked = 0;
	int cycles = 0;
	int n;
	always #2 clk = ~clk;
	ssr_supply_model ssr_supply_model_inst (.supply_mv(supply_mv), .detect_code(thr_sel),
		.uv_high(uv_thr), .below(below), .uv(uv), .rc_osc(rc));
	ssr_supervisor #(.DEBOUNCE_CYCLES(DEB), .RESET_HOLD(HOLD), .EDGES_PER_MS(1)) ssr_supervisor_inst (
		.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.supply_below_detect(below), .supply_at_or_below_uv(uv), .rc_osc_clk(rc),
		.opt_uv_reset_enable(opt_uv_en), .opt_uv_threshold_high(opt_uv_hi),
		.opt_watchdog_enable(opt_wd_en), .pc_value(pc), .fetch_valid(fetch),
		.fetch_opcode(opcode), .power_down(power_down), .detector_threshold_select(thr_sel),
		.undervoltage_threshold(uv_thr), .detector_interrupt(irq), .wake_request(wake),
		.reset_request(rst_req));
	task automatic finish_test();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		// Ends when waitrequest goes low; if it stays high, only the bench timeout ends it
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp, input string name);
		bus(1'b0, a, '0);
		check(name, exp, rd);
	endtask
	task automatic settle(input int c);
		repeat (c) @(posedge clk);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 10000) begin
			failures++;
			finish_test();
		end
	end
	initial begin
		settle(20);
		rst_n <= 1'b1;
		rd_chk(A_CTL, 32'h00, "control reset");
		rd_chk(A_STAT, 32'h20, "status reset");
		rd_chk(10'h100, 32'h00, "unmapped");
		bus(1'b1, A_CTL, 32'h83);
		supply_mv <= 13'd2700;
		settle(DEB - 3);
		supply_mv <= 13'd3000;
		settle(4);
		check("irq after dip", 32'h0, {31'h0, irq});
		supply_mv <= 13'd2700;
		settle(LAT);
		rd_chk(A_CTL, 32'hd3, "detect set");
		power_down <= 1'b1;
		settle(2);
		check("wake", 32'h1, {31'h0, wake});
		power_down <= 1'b0;
		supply_mv <= 13'd3000;
		settle(LAT);
		rd_chk(A_CTL, 32'h93, "irq sticky");
		bus(1'b1, A_CTL, 32'ha3);
		settle(LAT);
		rd_chk(A_CTL, 32'hf3, "above mode");
		bus(1'b1, A_CTL, 32'h2f);
		settle(LAT);
		rd_chk(A_CTL, 32'h2f, "disabled");
		check("code out", 32'hf, {28'h0, thr_sel});
		avs_byteenable <= 4'h0;
		bus(1'b1, A_CTL, 32'h80);
		avs_byteenable <= 4'h1;
		rd_chk(A_CTL, 32'h2f, "masked write");
		opt_uv_en <= 1'b1;
		supply_mv <= 13'd2000;
		settle(DEB - 3);
		supply_mv <= 13'd3000;
		settle(4);
		check("uv short dip", 32'h0, {31'h0, rst_req});
		supply_mv <= 13'd2000;
		settle(LAT);
		check("uv reset", 32'h1, {31'h0, rst_req});
		rd_chk(A_STAT, 32'h30, "uv flag");
		supply_mv <= 13'd5000;
		settle(LAT);
		check("uv release", 32'h0, {31'h0, rst_req});
		opt_uv_hi <= 1'b1;
		settle(6);
		supply_mv <= 13'd4200;
		settle(LAT);
		check("uv high level", 32'h1, {31'h0, rst_req});
		supply_mv <= 13'd5000;
		opt_uv_en <= 1'b0;
		settle(LAT);
		supply_mv <= 13'd2000;
		settle(LAT);
		check("uv off", 32'h0, {31'h0, rst_req});
		supply_mv <= 13'd5000;
		bus(1'b1, A_STAT, 32'h00);
		rd_chk(A_STAT, 32'h00, "flags cleared");
		for (int i = 0; i < 3; i++) begin
			pc <= (i == 0) ? 16'h4000 : 16'h3fff;
			opcode <= (i == 1) ? 8'ha5 : 8'h00;
			fetch <= 1'b1;
			@(posedge clk);
			fetch <= 1'b0;
			settle(2);
			check("range reset", (i < 2) ? 32'h1 : 32'h0, {31'h0, rst_req});
			settle(HOLD + 4);
			rd_chk(A_STAT, (i < 2) ? 32'h80 : 32'h00, "range flag");
			bus(1'b1, A_STAT, 32'h00);
		end
		opt_wd_en <= 1'b1;
		bus(1'b1, A_STAT, 32'h06);
		for (int i = 0; i < 8; i++) begin
			settle(15);
			rd_chk(A_STAT, 32'h06, "watchdog kept");
		end
		n = 0;
		while (rst_req !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		check("watchdog reset", 32'h1, {31'h0, rst_req});
		check("period length", 32'h1, {31'h0, n >= 28 && n <= 60});
		rd_chk(A_STAT, 32'h86, "overflow flag");
		opt_wd_en <= 1'b0;
		settle(4);
		bus(1'b1, A_STAT, 32'h06);
		settle(200);
		rd_chk(A_STAT, 32'h06, "watchdog off");
		finish_test();
	end
endmodule // tb_ssr_supervisor
